// [rtl/pap_port.sv]
// port a pin control top: apb register file, input sampling, pad drive
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Contract
// - pin seven pulls low or releases only
// - highest priority enabled function owns pin
// - fixed per-pin priority, latch lowest
// - digital outputs still drive analog pins
// - analog inputs connect only in analog mode
// - level bits follow pins, bit four zero
// - pin five level bit read only
// - direction one tri-states, zero drives
// - pin five direction reads one always
// - pull-up bits only pins zero-three, five
// - pull-up needs global, input, enable, digital
// - pin five pull-up on with reset config
// - analog bits pins zero-three, reset one
// - analog disables input buffer, pull-up, change
// - unimplemented bits ignore writes, read zero
// - level read returns pins, write sets latch
// - analog pin reads zero digitally
// - pull-up off for output or alternate
// - global pull-up disable set at reset
module pap_port (
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [7:0]           pin_i,
  output logic      [7:0]           pin_o,
  output logic      [7:0]           pin_oe,
  output logic      [7:0]           pullup_on,
  output logic      [7:0]           analog_connect,
  output logic      [7:0]           digital_in,
  output logic      [7:0]           ioc_enable_mask,
  input  wire logic                 master_reset_input_config,
  input  wire pap_pkg::pap_periph_s periph
);
  import pap_pkg::*;

  logic [7:0]  latch_r;
  logic [7:0]  dir_r;
  logic [7:0]  pullup_r;
  logic [7:0]  analog_r;
  logic [7:0]  option_r;
  logic [7:0]  pins_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  pap_pad_s    pad_r;
  logic [7:0]  ana_conn_r;
  logic [7:0]  dig_in_r;
  logic [7:0]  ioc_r;

  logic [7:0]  mux_o;
  logic [7:0]  mux_oe;
  logic [7:0]  alt_own;
  logic [7:0]  pu_on;
  logic [7:0]  level_rd;
  logic [7:0]  dir_rd;
  logic [7:0]  wbyte;
  logic        setup;
  logic        wr;
  logic        rd;
  logic        hit_level;
  logic        hit_dir;
  logic        hit_pullup;
  logic        hit_analog;
  logic        hit_option;
  logic        hit_any;
  logic [7:0]  rd_byte;

  // apb decode: one wait-free access cycle after setup
  assign setup      = psel & ~penable;
  assign wr         = psel & penable & pwrite & pready_r & ~pslverr_r;
  assign rd         = setup & ~pwrite;
  assign wbyte      = pwdata[7:0];
  assign hit_level  = (paddr == PAP_OFF_LEVEL);
  assign hit_dir    = (paddr == PAP_OFF_DIR);
  assign hit_pullup = (paddr == PAP_OFF_PULLUP);
  assign hit_analog = (paddr == PAP_OFF_ANALOG);
  assign hit_option = (paddr == PAP_OFF_OPTION);
  assign hit_any    = hit_level | hit_dir | hit_pullup | hit_analog | hit_option;

  // analog pins read zero, bit four absent
  assign level_rd = pins_r & ~analog_r & PAP_LEVEL_MASK;
  assign dir_rd   = (dir_r & PAP_DIR_MASK) | PAP_DIR_FORCED;
  assign rd_byte  = hit_level  ? level_rd :
                    hit_dir    ? dir_rd :
                    hit_pullup ? (pullup_r & PAP_PULLUP_MASK) :
                    hit_analog ? (analog_r & PAP_ANALOG_MASK) :
                    hit_option ? option_r : 8'h00;

  // bus answer: setup cycle loads data, access cycle completes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit_any;
      prdata_r  <= rd ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // register writes at the completing access edge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      latch_r  <= PAP_LATCH_RST;
      dir_r    <= PAP_DIR_RST;
      pullup_r <= PAP_PULLUP_RST;
      analog_r <= PAP_ANALOG_RST;
      option_r <= PAP_OPTION_RST;
    end else if (clk_en && wr) begin
      if (hit_level) latch_r <= wbyte & PAP_LATCH_MASK;
      if (hit_dir) dir_r <= (wbyte & PAP_DIR_MASK) | PAP_DIR_FORCED;
      if (hit_pullup) pullup_r <= wbyte & PAP_PULLUP_MASK;
      if (hit_analog) analog_r <= wbyte & PAP_ANALOG_MASK;
      if (hit_option) option_r <= wbyte;
    end
  end

  // pin sampling and registered pad outputs
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pins_r     <= 8'h00;
      pad_r      <= '0;
      ana_conn_r <= 8'h00;
      dig_in_r   <= 8'h00;
      ioc_r      <= 8'h00;
    end else if (clk_en) begin
      pins_r          <= pin_i & PAP_LEVEL_MASK;
      pad_r.pin_o     <= mux_o;
      pad_r.pin_oe    <= mux_oe;
      pad_r.pullup_on <= pu_on;
      ana_conn_r      <= analog_r & PAP_ANALOG_MASK;
      dig_in_r        <= pin_i & ~analog_r & PAP_LEVEL_MASK;
      ioc_r           <= ~analog_r & PAP_LEVEL_MASK;
    end
  end

  pap_prio_mux u_mux (
    .latch   (latch_r),
    .dir     (dir_r),
    .per     (periph),
    .pin_o   (mux_o),
    .pin_oe  (mux_oe),
    .alt_own (alt_own)
  );

  pap_pullup u_pu (
    .pullup_en               (pullup_r),
    .dir                     (dir_r),
    .analog                  (analog_r),
    .alt_own                 (alt_own),
    .global_pullup_disable_n (option_r[PAP_GPU_BIT]),
    .master_reset_input_config             (master_reset_input_config),
    .pullup_on               (pu_on)
  );

  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign pin_o           = pad_r.pin_o;
  assign pin_oe          = pad_r.pin_oe;
  assign pullup_on       = pad_r.pullup_on;
  assign analog_connect  = ana_conn_r;
  assign digital_in      = dig_in_r;
  assign ioc_enable_mask = ioc_r;
endmodule : pap_port

// [rtl/pap_pkg.sv]
// package: register map, field masks, reset values and carrier structs for port a
package pap_pkg;
  localparam int          PAP_NPIN        = 8;
  localparam logic [11:0] PAP_OFF_LEVEL   = 12'h000;
  localparam logic [11:0] PAP_OFF_DIR     = 12'h004;
  localparam logic [11:0] PAP_OFF_PULLUP  = 12'h008;
  localparam logic [11:0] PAP_OFF_ANALOG  = 12'h00C;
  localparam logic [11:0] PAP_OFF_OPTION  = 12'h010;
  localparam logic [7:0]  PAP_LEVEL_MASK  = 8'hEF;
  localparam logic [7:0]  PAP_LATCH_MASK  = 8'hCF;
  localparam logic [7:0]  PAP_DIR_MASK    = 8'hCF;
  localparam logic [7:0]  PAP_DIR_FORCED  = 8'h20;
  localparam logic [7:0]  PAP_PULLUP_MASK = 8'h2F;
  localparam logic [7:0]  PAP_ANALOG_MASK = 8'h0F;
  localparam logic [7:0]  PAP_OD_MASK     = 8'hA0;
  localparam logic [7:0]  PAP_DIR_RST     = 8'hEF;
  localparam logic [7:0]  PAP_PULLUP_RST  = 8'h2F;
  localparam logic [7:0]  PAP_ANALOG_RST  = 8'h0F;
  localparam logic [7:0]  PAP_OPTION_RST  = 8'hFF;
  localparam logic [7:0]  PAP_LATCH_RST   = 8'h00;
  localparam int          PAP_GPU_BIT     = 7;
  localparam int          PAP_MASTER_RESET_INPUT_PIN    = 5;

  // peripheral output requests, an enable bit and a value bit per function
  typedef struct packed {
    logic test_out_en;
    logic test_out;
    logic clock_pin_en;
    logic clock_pin;
    logic timer_clock_en;
    logic timer_clock;
    logic ext_int_en;
    logic ext_int;
    logic master_reset_en;
    logic master_reset;
    logic test_enable_en;
    logic test_enable;
    logic ccd_en;
    logic ccd;
    logic prog_data_en;
    logic prog_data;
    logic i2c_clock_en;
    logic i2c_clock;
  } pap_periph_s;

  // per-pin pad drive
  typedef struct packed {
    logic [7:0] pin_o;
    logic [7:0] pin_oe;
    logic [7:0] pullup_on;
  } pap_pad_s;
endpackage : pap_pkg

// [rtl/pap_prio_mux.sv]
// output priority multiplexer for the port a pins
`timescale 1ns/1ns
module pap_prio_mux (
  input  wire logic [7:0]          latch,
  input  wire logic [7:0]          dir,
  input  wire pap_pkg::pap_periph_s per,
  output logic      [7:0]          pin_o,
  output logic      [7:0]          pin_oe,
  output logic      [7:0]          alt_own
);
  import pap_pkg::*;
  logic [7:0] alt_en;
  logic [7:0] alt_val;
  logic [7:0] val;
  logic [7:0] drive;

  assign alt_en[0] = per.test_out_en;
  assign alt_val[0] = per.test_out;
  assign alt_en[1] = per.clock_pin_en;
  assign alt_val[1] = per.clock_pin;
  assign alt_en[2] = per.ext_int_en | per.timer_clock_en;
  assign alt_val[2] = per.ext_int_en ? per.ext_int : per.timer_clock;
  assign alt_en[3] = 1'b0;
  assign alt_val[3] = 1'b0;
  assign alt_en[4] = 1'b0;
  assign alt_val[4] = 1'b0;
  assign alt_en[5] = per.test_enable_en | per.master_reset_en;
  assign alt_val[5] = per.test_enable_en ? per.test_enable : per.master_reset;
  assign alt_en[6] = per.prog_data_en | per.ccd_en;
  assign alt_val[6] = per.prog_data_en ? per.prog_data : per.ccd;
  assign alt_en[7] = per.i2c_clock_en;
  assign alt_val[7] = per.i2c_clock;

  assign alt_own = alt_en & PAP_LEVEL_MASK;
  // highest enabled function wins, latch lowest; analog mode not considered
  assign val   = (alt_own & alt_val) | (~alt_own & latch);
  assign drive = ~dir & PAP_LEVEL_MASK & ~PAP_DIR_FORCED;

  genvar g;
  for (g = 0; g < PAP_NPIN; g++) begin : g_pin
    if (PAP_OD_MASK[g]) begin : g_od
      // open drain: pull low only, never high
      assign pin_o[g]  = 1'b0;
      assign pin_oe[g] = drive[g] & ~val[g];
    end else begin : g_cmos
      assign pin_o[g]  = val[g];
      assign pin_oe[g] = drive[g];
    end
  end
endmodule : pap_prio_mux

// [rtl/pap_pullup.sv]
// weak pull-up qualification for the port a pins
`timescale 1ns/1ns
module pap_pullup (
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] dir,
  input  wire logic [7:0] analog,
  input  wire logic [7:0] alt_own,
  input  wire logic       global_pullup_disable_n,
  input  wire logic       master_reset_input_config,
  output logic      [7:0] pullup_on
);
  import pap_pkg::*;
  logic [7:0] sw_pu;
  logic [7:0] master_reset_input_pu;

  assign sw_pu = {8{~global_pullup_disable_n}} & dir & pullup_en
               & ~analog & ~alt_own & PAP_PULLUP_MASK;
  assign master_reset_input_pu = master_reset_input_config ? (8'h01 << PAP_MASTER_RESET_INPUT_PIN) : 8'h00;
  assign pullup_on = master_reset_input_config ? ((sw_pu & ~master_reset_input_pu) | master_reset_input_pu) : sw_pu;
endmodule : pap_pullup

// [sim/pap_pads.sv]
// pad model: external circuitry on the port a pins
`timescale 1ns/1ns
module pap_pads (
  input  wire logic       sys_clk,
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_lvl
);
  logic [7:0] float_r = 8'h5a;
  // floating pins wander so a stale level never reads as valid
  always @(posedge sys_clk) float_r <= ~float_r;
  assign pin_lvl = (pin_oe & pin_o)
                 | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pullup_on | float_r));
endmodule : pap_pads

// [sim/pap_port_asserts.sv]
// checker: port a pin control assertions
`timescale 1ns/1ns
module pap_port_asserts (
  input wire logic                 sys_clk,
  input wire logic                 srst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [11:0]          paddr,
  input wire logic [31:0]          pwdata,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic [7:0]           pin_o,
  input wire logic [7:0]           pin_oe,
  input wire logic [7:0]           pullup_on,
  input wire logic [7:0]           analog_connect,
  input wire logic                 master_reset_input_config
);
  import pap_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_dir_wr; psel && penable && pready && pwrite && paddr == PAP_OFF_DIR; endsequence
  sequence s_dir_rd; psel && !penable && !pwrite && paddr == PAP_OFF_DIR; endsequence
  a_od_low: assert property ((pin_oe & pin_o & 8'ha0) == 8'h00)
    else $error("open drain pin driven high");
  a_no_drive45: assert property (pin_oe[5:4] == 2'b00)
    else $error("input only pin driven");
  a_pull_gate: assert property (
    (pullup_on & (pin_oe | 8'hd0 | analog_connect)) == 8'h00)
    else $error("pull-up on where it must be off");
  a_master_reset_input_pull: assert property (master_reset_input_config |=> pullup_on[5])
    else $error("reset pin pull-up off");
  a_glob_pull: assert property ($past(srst) && !master_reset_input_config |=> pullup_on == 8'h00)
    else $error("pull-up on after reset");
  a_setup_ready: assert property (s_setup |=> pready ##1 !pready)
    else $error("bus answer not a single pulse after setup");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error answer malformed");
  a_dir5_read: assert property (s_dir_rd |=> prdata[5:4] == 2'b10)
    else $error("direction read bits five and four wrong");
  a_dir_oe: assert property (
    s_dir_wr |-> ##2 pin_oe[3:0] == ~$past(pwdata[3:0], 2))
    else $error("driver enable does not follow direction");
endmodule : pap_port_asserts

bind pap_port pap_port_asserts u_chk (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .pin_o, .pin_oe, .pullup_on, .analog_connect,
  .master_reset_input_config);

// [sim/tb_pap_port.sv]
// testbench: port a registers, pads and output priorities
`timescale 1ns/1ns
module tb_pap_port;
  import pap_pkg::*;
  logic        sys_clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        master_reset_input_config = 1'b0;
  logic        clk_en = 1'b1;
  logic        pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [7:0]  pin_lvl, pin_o, pin_oe, pullup_on, q, d, e, an;
  logic [7:0]  dig_in, ioc_mask, ana_conn;
  logic [7:0]  ext_en = 8'hff;
  logic [7:0]  ext_val = 8'hff;
  pap_periph_s periph = '0;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          seed = 32'h9509;
  logic [17:0] pv [8] = '{18'h2_0000, 18'h0_8000, 18'h0_3800, 18'h0_2c00,
                          18'h0_0038, 18'h0_002c, 18'h0_0002, 18'h0_0280};
  logic [7:0]  po [8] = '{8'h4e, 8'h4d, 8'h4b, 8'h4f, 8'h0f, 8'h4f, 8'h4f, 8'h4f};
  logic [11:0] offs [4] = '{PAP_OFF_DIR, PAP_OFF_PULLUP, PAP_OFF_ANALOG, PAP_OFF_OPTION};

  pap_port uut (.sys_clk, .srst, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pin_i(pin_lvl), .pin_o, .pin_oe, .pullup_on,
    .analog_connect(ana_conn), .digital_in(dig_in), .ioc_enable_mask(ioc_mask),
    .master_reset_input_config, .periph);
  pap_pads u_pads (.sys_clk, .pin_o, .pin_oe, .pullup_on, .ext_en, .ext_val, .pin_lvl);

  initial forever #50 sys_clk = ~sys_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  always @(posedge sys_clk) begin
    if (++cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, v};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic wt;
    repeat (2) @(posedge sys_clk);
  endtask : wt

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(q, x);
  endtask : rd

  task automatic pu(input logic [11:0] a, input logic [7:0] v, input logic [7:0] x);
    apb(1'b1, a, v);
    wt();
    chk(pullup_on, x);
  endtask : pu

  function automatic logic [7:0] reg_exp(input int j, input logic [7:0] v);
    case (j)
      0: return (v & 8'hcf) | 8'h20;
      1: return v & 8'h2f;
      2: return v & 8'h0f;
      default: return v;
    endcase
  endfunction : reg_exp

  function automatic logic [7:0] lvl_exp(input logic [7:0] v, x, a);
    return ((v & 8'h4f) | (v & x & 8'h80) | (x & 8'h20)) & ~a;
  endfunction : lvl_exp

  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    for (int j = 0; j < 4; j++) rd(offs[j], reg_exp(j, 8'hff));
    rd(12'h014, 8'h00);
    chk({7'h00, err}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      d = 8'($random(seed));
      apb(1'b1, offs[i % 4], d);
      rd(offs[i % 4], reg_exp(i % 4, d));
    end
    apb(1'b1, PAP_OFF_ANALOG, 8'h0f);
    apb(1'b1, PAP_OFF_DIR, 8'h00);
    apb(1'b1, PAP_OFF_LEVEL, 8'hff);
    for (int i = 0; i < 8; i++) begin
      periph <= pv[i];
      wt();
      chk(pin_o, po[i]);
      chk(pin_oe, (pv[i] == 18'h0_0002) ? 8'hcf : 8'h4f);
    end
    clk_en <= 1'b0;
    periph <= pv[0];
    wt();
    chk(pin_o, 8'h4f);
    clk_en <= 1'b1;
    wt();
    chk(pin_o, 8'h4e);
    periph <= '0;
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      e = 8'($random(seed));
      an = 8'($random(seed)) & 8'h0f;
      ext_val <= e;
      apb(1'b1, PAP_OFF_ANALOG, an);
      apb(1'b1, PAP_OFF_LEVEL, d);
      wt();
      rd(PAP_OFF_LEVEL, lvl_exp(d, e, an));
      chk(dig_in, lvl_exp(d, e, an));
      chk(ioc_mask, ~an & 8'hef);
      chk(ana_conn, an);
    end
    ext_val <= 8'hff;
    ext_en <= 8'hc0;
    apb(1'b1, PAP_OFF_DIR, 8'hff);
    apb(1'b1, PAP_OFF_ANALOG, 8'h03);
    pu(PAP_OFF_OPTION, 8'hff, 8'h00);
    pu(PAP_OFF_PULLUP, 8'hff, 8'h00);
    pu(PAP_OFF_OPTION, 8'h7f, 8'h2c);
    rd(PAP_OFF_LEVEL, 8'hec);
    chk(dig_in, 8'hec);
    chk(ioc_mask, 8'hec);
    chk(ana_conn, 8'h03);
    pu(PAP_OFF_DIR, 8'hf7, 8'h24);
    periph <= 18'h0_2000;
    wt();
    chk(pullup_on, 8'h20);
    periph <= '0;
    pu(PAP_OFF_OPTION, 8'hff, 8'h00);
    master_reset_input_config <= 1'b1;
    pu(PAP_OFF_PULLUP, 8'h00, 8'h20);
    test_done();
  end
endmodule : tb_pap_port
